// ---- scaler_map.svh ----
// Register offsets, field positions, reset values and constants of the prescaler
`ifndef SCALER_MAP_SVH
`define SCALER_MAP_SVH
`define SC_OFS_CTRL_A   8'h90
`define SC_OFS_PSC_A    8'hA0
`define SC_OFS_ACL_A    8'hA1
`define SC_OFS_GAIN_A   8'hA2
`define SC_OFS_CTRL_B   8'hC0
`define SC_OFS_PSC_B    8'hD0
`define SC_OFS_ACL_B    8'hD1
`define SC_OFS_GAIN_B   8'hD2
`define SC_BIT_OFID     6
`define SC_BIT_CMARK    7
`define SC_BIT_WEIGHT   3
`define SC_RST_CTRL     8'h00
`define SC_RST_PSC      8'h01
`define SC_RST_ACL      8'h00
`define SC_RST_GAIN     8'h00
`define SC_FINE_UNITY   13'h0400
`define SC_ACC_DEPTH    64
`endif

// ---- scaler_pkg.sv ----
// Types shared by the field identifier and horizontal prescaler logic
`default_nettype none
package scaler_pkg;
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] c;
      logic       first;
      logic       last;
   } pix_in_t;
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] c;
      logic [5:0] phase;
   } pix_out_t;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] psc;
      logic [7:0] acl;
      logic [7:0] gain;
   } reg_set_t;
   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_LINE = 2'b01
   } line_state_t;
endpackage : scaler_pkg
`default_nettype wire

// ---- scaler_hpre.sv ----
// Output field identifier selection and horizontal prescaler with two-entry output buffer
// Function
// - Select bit 0: input field ID out
// - Select bit 1: toggle flag is field ID
// - Per-task toggle flips at each task start
// - Toggle not synchronised to input field ID
// - Marker bit clear: D7 high, set inverts
// - Task pin mode shows marker bit
// - Scale is prescale reciprocal times fine ratio
// - Integer prescale field, values 1 to 63
// - Fine phase resolution is six bits
// - Length field 0..63 gives 1..64 pixels
// - Gain field shifts result down 0..7
// - Weight bit: flat or 1-2-...-2-1 weights
// - Prefilter plus accumulator form FIR lowpass
// - Prefilter stage precedes integer prescaler
// - Selectable prefilter lowpass responses
// - Separate register sets per task
// - Two-bit luma and chroma prefilter selects
// - DC gain follows weight and length
// - Original sample copied first and last
`timescale 1ns/1ps
`default_nettype none
`include "scaler_map.svh"
module scaler_hpre (
   input  wire logic                clk_i,          // 20 MHz pixel clock
   input  wire logic                rst_n_i,        // Async reset, active low
   input  wire logic [7:0]          reg_addr_i,     // Register offset
   input  wire logic [7:0]          reg_wdata_i,    // Write data
   input  wire logic                reg_wr_i,       // Write strobe
   output logic [7:0]               reg_rdata_o,    // Read data, one cycle later
   input  wire logic                fid_i,          // Input field identifier
   input  wire logic                task_start_i,   // Task activation pulse
   input  wire logic                task_sel_i,     // Started task, 1 = B
   input  wire logic                pin_a_task_i,   // Pin A shows task flag
   input  wire logic                pin_b_task_i,   // Pin B shows task flag
   input  wire logic [12:0]         fine_inc_i,     // Fine scale increment
   output logic                     fid_o,          // Field ID, code bit D6
   output logic                     d7_o,           // Code bit D7
   output logic                     pin_a_o,        // General output pin A
   output logic                     pin_b_o,        // General output pin B
   input  wire logic                in_valid_i,     // Input pixel valid
   input  wire scaler_pkg::pix_in_t in_data_i,      // Input pixel
   output logic                     in_ready_o,     // Input pixel taken
   output logic                     out_valid_o,    // Output sample valid
   output scaler_pkg::pix_out_t     out_data_o,     // Output sample
   input  wire logic                out_ready_i     // Receiver ready
);
   // Returns {hit, task, field} for a register offset
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      unique case (a)
         `SC_OFS_CTRL_A: reg_index = 4'b1000;
         `SC_OFS_PSC_A:  reg_index = 4'b1001;
         `SC_OFS_ACL_A:  reg_index = 4'b1010;
         `SC_OFS_GAIN_A: reg_index = 4'b1011;
         `SC_OFS_CTRL_B: reg_index = 4'b1100;
         `SC_OFS_PSC_B:  reg_index = 4'b1101;
         `SC_OFS_ACL_B:  reg_index = 4'b1110;
         `SC_OFS_GAIN_B: reg_index = 4'b1111;
         default:        reg_index = 4'b0000;
      endcase
   endfunction : reg_index

   // Kernels normalised to a sum of 32
   function automatic logic [7:0] prefilt(input logic [7:0] a, b, c, d, e,
                                          input logic [1:0] sel);
      logic [12:0] s;
      s = 13'h0000;
      unique case (sel)
         2'b00: s = 13'(c) << 5;
         2'b01: s = (13'(b) + (13'(c) << 1) + 13'(d)) << 3;
         2'b10: s = 13'd3 * 13'(a) + 13'd8 * 13'(b) + 13'd10 * 13'(c)
                  + 13'd8 * 13'(d) + 13'd3 * 13'(e);
         2'b11: s = (13'(a) + (13'(b) << 1) + (13'(c) << 1) + (13'(d) << 1)
                  + 13'(e)) << 2;
      endcase
      return s[12:5];
   endfunction : prefilt

   scaler_pkg::reg_set_t    set_q [2];
   scaler_pkg::reg_set_t    set_d [2];
   scaler_pkg::reg_set_t    act_q, act_d;
   logic [7:0]              rdata_d;
   logic [3:0]              widx, ridx;
   logic [1:0]              tog_q, tog_d;
   logic                    cur_q, cur_d;
   logic                    fid_d, d7_d, pin_a_d, pin_b_d;

   always_comb begin
      widx  = reg_index(reg_addr_i);
      ridx  = reg_index(reg_addr_i);
      set_d = set_q;
      if (reg_wr_i && widx[3]) begin
         unique case (widx[1:0])
            2'b00: set_d[widx[2]].ctrl = reg_wdata_i;
            2'b01: set_d[widx[2]].psc  = {2'b00, reg_wdata_i[5:0]};
            2'b10: set_d[widx[2]].acl  = {2'b00, reg_wdata_i[5:0]};
            2'b11: set_d[widx[2]].gain = reg_wdata_i;
         endcase
      end
      unique case (ridx[1:0])
         2'b00: rdata_d = set_q[ridx[2]].ctrl;
         2'b01: rdata_d = set_q[ridx[2]].psc;
         2'b10: rdata_d = set_q[ridx[2]].acl;
         2'b11: rdata_d = set_q[ridx[2]].gain;
      endcase
      if (!ridx[3])
         rdata_d = 8'h00;
      act_d = act_q;
      tog_d = tog_q;
      cur_d = cur_q;
      if (task_start_i) begin
         act_d = set_q[task_sel_i];
         cur_d = task_sel_i;
         tog_d[task_sel_i] = ~tog_q[task_sel_i];
      end
      // Toggle is a pure activation count; the back end pairs it with fields
      fid_d   = act_q.ctrl[`SC_BIT_OFID] ? tog_q[cur_q] : fid_i;
      d7_d    = ~act_q.ctrl[`SC_BIT_CMARK];
      pin_a_d = pin_a_task_i ? act_q.ctrl[`SC_BIT_CMARK] : fid_d;
      pin_b_d = pin_b_task_i ? act_q.ctrl[`SC_BIT_CMARK] : fid_d;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 2; i++)
            set_q[i] <= '{`SC_RST_CTRL, `SC_RST_PSC, `SC_RST_ACL, `SC_RST_GAIN};
         act_q       <= '{`SC_RST_CTRL, `SC_RST_PSC, `SC_RST_ACL, `SC_RST_GAIN};
         reg_rdata_o <= 8'h00;
         tog_q       <= 2'b00;
         cur_q       <= 1'b0;
         fid_o       <= 1'b0;
         d7_o        <= 1'b1;
         pin_a_o     <= 1'b0;
         pin_b_o     <= 1'b0;
      end else begin
         set_q       <= set_d;
         act_q       <= act_d;
         reg_rdata_o <= rdata_d;
         tog_q       <= tog_d;
         cur_q       <= cur_d;
         fid_o       <= fid_d;
         d7_o        <= d7_d;
         pin_a_o     <= pin_a_d;
         pin_b_o     <= pin_b_d;
      end
   end

   // Prescaler control
   scaler_pkg::line_state_t ls_q, ls_d;
   logic [5:0]              wr_q, wr_d, cnt_q, cnt_d, psc;
   logic [6:0]              fill_q, fill_d, len;
   logic [9:0]              ph_q, ph_d;
   logic                    acc, first, last, emit, push;
   logic [7:0]              res [2];
   logic [7:0]              raw [2];

   assign raw[0] = in_data_i.y;
   assign raw[1] = in_data_i.c;

   always_comb begin
      acc   = in_valid_i && in_ready_o;
      first = in_data_i.first;
      last  = in_data_i.last;
      psc   = (act_q.psc[5:0] == 6'h00) ? 6'h01 : act_q.psc[5:0];
      len   = {1'b0, act_q.acl[5:0]} + 7'h01;
      emit  = first || last || (cnt_q == psc - 6'h01);
      push  = acc && emit && (first || ls_q == scaler_pkg::LS_LINE);
      ls_d  = ls_q;
      wr_d  = wr_q;
      fill_d = fill_q;
      cnt_d = cnt_q;
      ph_d  = ph_q;
      if (acc) begin
         wr_d   = wr_q + 6'h01;
         fill_d = first ? 7'h01 : (fill_q == 7'(`SC_ACC_DEPTH) ? fill_q : fill_q + 7'h01);
         cnt_d  = (first || cnt_q == psc - 6'h01) ? 6'h00 : cnt_q + 6'h01;
         unique case (ls_q)
            scaler_pkg::LS_IDLE: if (first && !last) ls_d = scaler_pkg::LS_LINE;
            scaler_pkg::LS_LINE: if (last) ls_d = scaler_pkg::LS_IDLE;
            default:             ls_d = scaler_pkg::LS_IDLE;
         endcase
         // Fine phase: 1024 units per input pixel of the prescaled grid
         if (push)
            ph_d = first ? 10'h000 : ph_q + fine_inc_i[9:0];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ls_q   <= scaler_pkg::LS_IDLE;
         wr_q   <= 6'h00;
         fill_q <= 7'h00;
         cnt_q  <= 6'h00;
         ph_q   <= 10'h000;
      end else begin
         ls_q   <= ls_d;
         wr_q   <= wr_d;
         fill_q <= fill_d;
         cnt_q  <= cnt_d;
         ph_q   <= ph_d;
      end
   end

   // One prefilter and accumulator per channel, 0 = luma, 1 = chroma
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [7:0]  win_q [4];
      logic [7:0]  win_d [4];
      logic [7:0]  mem_q [`SC_ACC_DEPTH];
      logic [13:0] sum_q, sum_d;
      logic [7:0]  pf, oldest, sub;
      logic [14:0] wsum, shifted;
      logic [1:0]  sel;

      always_comb begin
         sel = (ch == 0) ? act_q.gain[5:4] : act_q.gain[7:6];
         pf  = prefilt(raw[ch], win_q[0], win_q[1], win_q[2], win_q[3], sel);
         win_d = win_q;
         if (acc)
            win_d = '{raw[ch], win_q[0], win_q[1], win_q[2]};
         sub    = (fill_q >= len) ? mem_q[wr_q - len[5:0]] : 8'h00;
         oldest = (act_q.acl[5:0] == 6'h00) ? pf :
                  (fill_q >= {1'b0, act_q.acl[5:0]}) ? mem_q[wr_q - act_q.acl[5:0]] : 8'h00;
         sum_d  = sum_q;
         if (acc)
            sum_d = first ? 14'(pf) : sum_q + 14'(pf) - 14'(sub);
         // Gain = (w+1)*acl + (1-w) before the shift
         wsum = act_q.gain[`SC_BIT_WEIGHT] ?
                ({sum_d, 1'b0} - 15'(pf) - 15'(oldest)) : 15'(sum_d);
         shifted = wsum >> act_q.gain[2:0];
         // Saturate rather than wrap when gain is not renormalised
         res[ch] = (first || last) ? raw[ch] :
                   (|shifted[14:8] ? 8'hFF : shifted[7:0]);
      end

      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            win_q <= '{8'h00, 8'h00, 8'h00, 8'h00};
            sum_q <= 14'h0000;
         end else begin
            win_q <= win_d;
            sum_q <= sum_d;
         end
      end

      always_ff @(posedge clk_i) begin
         if (acc)
            mem_q[wr_q] <= pf;
      end
   end

   // Two-entry output buffer; head entry drives the port directly
   scaler_pkg::pix_out_t e0_q, e0_d, e1_q, e1_d, nw;
   logic                 v0_q, v0_d, v1_q, v1_d, rdy_d;

   always_comb begin
      nw   = '{res[0], res[1], ph_d[9:4]};
      e0_d = e0_q;
      e1_d = e1_q;
      v0_d = v0_q;
      v1_d = v1_q;
      if (v0_q && out_ready_i) begin
         e0_d = e1_q;
         v0_d = v1_q;
         v1_d = 1'b0;
      end
      if (push) begin
         if (!v0_d) begin
            e0_d = nw;
            v0_d = 1'b1;
         end else begin
            e1_d = nw;
            v1_d = 1'b1;
         end
      end
      rdy_d = !v1_d;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         e0_q       <= '0;
         e1_q       <= '0;
         v0_q       <= 1'b0;
         v1_q       <= 1'b0;
         in_ready_o <= 1'b0;
      end else begin
         e0_q       <= e0_d;
         e1_q       <= e1_d;
         v0_q       <= v0_d;
         v1_q       <= v1_d;
         in_ready_o <= rdy_d;
      end
   end

   assign out_valid_o = v0_q;
   assign out_data_o  = e0_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   fid_input_a: assert property (!act_q.ctrl[6] |=> fid_o == $past(fid_i))
      else $error("field ID does not follow input field");
   fid_toggle_a: assert property (act_q.ctrl[6] && !task_start_i
         |=> fid_o == tog_q[cur_q])
      else $error("field ID does not follow toggle");
   toggle_flip_a: assert property (task_start_i
         |=> (tog_q ^ $past(tog_q)) == (cur_q ? 2'b10 : 2'b01))
      else $error("toggle did not flip on task start");
   toggle_hold_a: assert property (!task_start_i |=> $stable(tog_q))
      else $error("toggle moved without task start");
   code_d7_a: assert property (##1 d7_o == !$past(act_q.ctrl[7]))
      else $error("code bit D7 wrong");
   task_pin_a: assert property (pin_a_task_i |=> pin_a_o == $past(act_q.ctrl[7]))
      else $error("task flag not on pin A");
   set_switch_a: assert property (task_start_i && task_sel_i
         |=> act_q == $past(set_q[1]))
      else $error("task B set not taken");
   full_rate_a: assert property (acc && psc == 6'h01 && ls_q == scaler_pkg::LS_LINE
         |-> push)
      else $error("unit prescale dropped a pixel");
   edge_copy_a: assert property (acc && first && !v0_q |=> out_valid_o
         && out_data_o.y == $past(in_data_i.y))
      else $error("first pixel not copied");
   hold_stall_a: assert property (out_valid_o && !out_ready_i
         |=> out_valid_o && $stable(out_data_o))
      else $error("stalled word changed");

   task_b_c: cover property (task_start_i && task_sel_i ##1 fid_o);
   decimate_c: cover property (push && psc > 6'h02 && !first && !last);
   full_c: cover property (v1_q && !out_ready_i);
endmodule : scaler_hpre
`default_nettype wire

// ---- capture_sink.sv ----
// Back-end capture model that takes the prescaled stream, with stalls
`timescale 1ns/1ps
`default_nettype none
module capture_sink (
   input  wire logic                 clk_i,   // Pixel clock
   input  wire logic                 rst_n_i, // Reset sampled on falling clock edge, active low
   input  wire logic                 hold_i,  // Stall the stream fully
   input  wire logic                 valid_i, // Sample offered
   input  wire scaler_pkg::pix_out_t data_i,  // Offered sample
   output logic                      ready_o  // Receiver ready
);
   scaler_pkg::pix_out_t rx_q[$];
   logic                 slow_q;
   // Ready every other cycle only, so the buffer always sees a slow receiver
   always @(negedge clk_i) begin
      slow_q  <= ~slow_q & rst_n_i;
      ready_o <= rst_n_i & ~hold_i & slow_q;
   end
   always @(posedge clk_i) begin
      if (valid_i && ready_o) rx_q.push_back(data_i);
   end
endmodule : capture_sink
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for field identifier selection and horizontal prescaling
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic                 clk_i, rst_n_i, reg_wr_i, fid_i, task_start_i, task_sel_i, hold;
   logic                 pin_a_task_i, pin_b_task_i, in_valid_i, in_ready_o, out_valid_o;
   logic                 fid_o, d7_o, pin_a_o, pin_b_o, out_ready_i;
   logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [12:0]          fine_inc_i;
   scaler_pkg::pix_in_t  in_data_i;
   scaler_pkg::pix_out_t out_data_o, s;
   int                   num_errors, cmp_count, k;
   logic [7:0]           cfg [4][5];
   scaler_hpre dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o),
      .fid_i(fid_i), .task_start_i(task_start_i), .task_sel_i(task_sel_i),
      .pin_a_task_i(pin_a_task_i), .pin_b_task_i(pin_b_task_i), .fine_inc_i(fine_inc_i),
      .fid_o(fid_o), .d7_o(d7_o), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o),
      .in_valid_i(in_valid_i), .in_data_i(in_data_i), .in_ready_o(in_ready_o),
      .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_ready_i(out_ready_i));
   capture_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .hold_i(hold),
      .valid_i(out_valid_o), .data_i(out_data_o), .ready_o(out_ready_i));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
      @(negedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_i = a;
      @(negedge clk_i);
      chk("reg_rdata_o", e, reg_rdata_o);
   endtask : rd
   // Outputs follow a start two edges later
   task automatic start(input logic sel);
      task_sel_i = sel;
      task_start_i = 1'b1;
      @(negedge clk_i);
      task_start_i = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask : start
   task automatic pins(input logic [3:0] e);
      chk("fid_d7_pins", {4'h0, e}, {4'h0, fid_o, d7_o, pin_a_o, pin_b_o});
   endtask : pins
   // Seven pixels; valid stays up between pixels
   task automatic line(input logic ramp, input logic [7:0] v);
      int i;
      for (i = 0; i < 7; i++) begin
         in_valid_i = 1'b1;
         in_data_i = '{y: ramp ? 8'(i * 16 + 8) : v, c: ramp ? 8'(i * 16 + 8) : v,
                       first: i == 0, last: i == 6};
         while (in_ready_o !== 1'b1) @(negedge clk_i);
         @(negedge clk_i);
      end
      in_valid_i = 1'b0;
   endtask : line
   // Raw copies at both ends; inner ones at pixels 2 and 4, bypass tap two pixels back
   task automatic expect_line(input logic ramp, input logic [7:0] v, input logic [7:0] x1,
                              input logic [7:0] x);
      int j;
      logic [7:0] e;
      repeat (20) @(negedge clk_i);
      chk("sample count", 8'h04, 8'(sink.rx_q.size()));
      for (j = 0; j < 4 && sink.rx_q.size() > 0; j++) begin
         s = sink.rx_q.pop_front();
         e = (j == 0) ? (ramp ? 8'h08 : v) : (j == 3) ? (ramp ? 8'h68 : v)
           : (ramp ? 8'(j * 32 - 24) : (j == 1 ? x1 : x));
         chk("out y", e, s.y);
         chk("out c", e, s.c);
         chk("out phase", 8'(j * 20), {2'b00, s.phase});
      end
   endtask : expect_line
   task automatic report_and_stop();
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      #200_000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      {rst_n_i, reg_wr_i, fid_i, task_start_i, task_sel_i, in_valid_i, hold} = '0;
      {pin_a_task_i, pin_b_task_i, reg_addr_i, reg_wdata_i} = '0;
      in_data_i = '0;
      fine_inc_i = 13'h0540;
      cfg = '{'{8'h01, 8'h00, 8'hC0, 8'hFF, 8'hFF}, '{8'h01, 8'h01, 8'h40, 8'h80, 8'h40},
              '{8'h02, 8'h0A, 8'h40, 8'h40, 8'h40}, '{8'h00, 8'hF0, 8'h40, 8'h40, 8'h40}};
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_i);
      chk("d7 reset", 8'h01, {7'h0, d7_o});
      rd(8'h90, 8'h00);
      rd(8'hA0, 8'h01);
      rd(8'hA1, 8'h00);
      rd(8'hA2, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'hA0, 8'hC4);
      wr(8'hD0, 8'h3F);
      rd(8'hA0, 8'h04);
      rd(8'hD0, 8'h3F);
      wr(8'h90, 8'h40);
      wr(8'hC0, 8'h80);
      pin_a_task_i = 1'b1;
      start(1'b0);
      pins(4'b1101);
      fid_i = 1'b1;
      start(1'b0);
      pins(4'b0100);
      fid_i = 1'b0;
      start(1'b1);
      pins(4'b0010);
      wr(8'hC0, 8'h00);
      pins(4'b0010);
      start(1'b0);
      pins(4'b1101);
      wr(8'hA0, 8'h02);
      wr(8'hA1, 8'h00);
      wr(8'hA2, 8'h00);
      start(1'b0);
      hold = 1'b1;
      fork
         line(1'b1, 8'h00);
         begin
            repeat (8) @(negedge clk_i);
            chk("in_ready held", 8'h00, {7'h0, in_ready_o});
            hold = 1'b0;
         end
      join
      expect_line(1'b1, 8'h00, 8'h00, 8'h00);
      for (k = 0; k < 4; k++) begin
         wr(8'hA1, cfg[k][0]);
         wr(8'hA2, cfg[k][1]);
         start(1'b0);
         line(1'b0, cfg[k][2]);
         expect_line(1'b0, cfg[k][2], cfg[k][3], cfg[k][4]);
      end
      wr(8'hA0, 8'h01);
      start(1'b0);
      line(1'b0, 8'h40);
      repeat (20) @(negedge clk_i);
      chk("full rate count", 8'h07, 8'(sink.rx_q.size()));
      while (sink.rx_q.size() > 0) begin
         s = sink.rx_q.pop_front();
         chk("full rate y", 8'h40, s.y);
      end
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
